// >>> hw/pmcw_top.sv
// Purpose: read-only power management capability word at configuration offset 46h
// Assumes: misc config register lives elsewhere and presents a load strobe with its value
// Notes:   one cycle read latency; every output comes straight from a flip-flop
`timescale 1ns/1ps
module pmcw_top
  import pmcw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        cfg_read,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  input  wire logic        misc_load,
  input  wire logic [15:0] misc_value,
  output logic             cfg_ack,
  output logic [15:0]      cfg_rdata,
  output logic             wake_from_cold_off_capable
);

  logic        wake_from_state_two_select;
  logic        state_two_supported;
  logic [15:0] cap_word;
  logic        cap_hit;
  logic        loaded_since_reset;

  ////////////////////////////////////////////////////////////////////////////////
  // assemble the word from mirrors and constants
  function automatic logic [15:0] pmcw_build(
    input logic cold,
    input logic src_d2,
    input logic d2_sup
  );
    logic [15:0] w;
    w = 16'h0000;
    w[PMCW_COLD_BIT] = cold;
    w[PMCW_SRC_HI] = PMCW_SRC_HOT_D3[1];
    w[PMCW_SRC_D2_BIT] = src_d2;
    w[PMCW_SRC_D2_BIT-1] = PMCW_SRC_STATE_ONE;
    w[PMCW_SRC_LO] = PMCW_SRC_STATE_ZERO;
    w[PMCW_D2_SUP_BIT] = d2_sup;
    w[PMCW_D1_SUP_BIT] = 1'b0;
    w[PMCW_AUX_HI:PMCW_AUX_LO] = cold ? PMCW_AUX_55MA : PMCW_AUX_SELF;
    w[PMCW_DSI_BIT] = 1'b0;
    w[PMCW_RSVD_BIT] = 1'b0;
    w[PMCW_CLK_BIT] = 1'b0;
    w[PMCW_VER_HI:0] = PMCW_VERSION;
    return w;
  endfunction

  assign cap_word = pmcw_build(wake_from_cold_off_capable, wake_from_state_two_select,
                               state_two_supported);
  assign cap_hit  = (cfg_addr == PMCW_CAP_OFFSET);

  ////////////////////////////////////////////////////////////////////////////////
  // mirrors of the misc config bits; the rom loader and host updates both arrive
  // as a load of the whole misc register, so only one path has to be trusted
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wake_from_cold_off_capable <= PMCW_COLD_RESET;
      wake_from_state_two_select <= PMCW_SRC_D2_RESET;
      state_two_supported        <= PMCW_D2_SUP_RESET;
    end
    else if (misc_load)
    begin
      wake_from_cold_off_capable <= misc_value[PMCW_COLD_BIT];
      wake_from_state_two_select <= misc_value[PMCW_SRC_D2_BIT];
      state_two_supported        <= misc_value[PMCW_D2_SUP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration answer: reads of other offsets return zero, writes are
  // acknowledged but never stored, so no field can be forced by software
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 16'h0000;
    end
    else
    begin
      cfg_ack <= cfg_read | cfg_write;
      if (cfg_read)
        cfg_rdata <= cap_hit ? cap_word : 16'h0000;
      else if (cfg_write && cap_hit && (cfg_wdata != cap_word))
        cfg_rdata <= cfg_rdata; // write data dropped
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // check helper: remembers whether a misc load has happened since reset,
  // so the default word can be checked on any read before the first load
  always_ff @(posedge clock)
  begin
    if (reset)
      loaded_since_reset <= 1'b0;
    else if (misc_load)
      loaded_since_reset <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cold_bit;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=> cfg_ack && (cfg_rdata[15] == $past(wake_from_cold_off_capable));
  endproperty
  a_cold_bit: assert property (p_cold_bit) else $error("bit 15 not cold wake mirror");

  property p_src_const;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=> (cfg_rdata[14] && !cfg_rdata[12] && !cfg_rdata[11]);
  endproperty
  a_src_const: assert property (p_src_const) else $error("wake source constant bits wrong");

  property p_src_d2;
    @(posedge clock) disable iff (reset)
    (misc_load ##1 (cfg_read && cap_hit && !misc_load)) |=>
      (cfg_rdata[13] == $past(misc_value[13], 2));
  endproperty
  a_src_d2: assert property (p_src_d2) else $error("bit 13 does not follow misc");

  property p_d2_sup;
    @(posedge clock) disable iff (reset)
    (misc_load ##1 (cfg_read && cap_hit && !misc_load)) |=>
      (cfg_rdata[10] == $past(misc_value[10], 2));
  endproperty
  a_d2_sup: assert property (p_d2_sup) else $error("bit 10 does not follow misc");

  property p_fixed_zero;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=> (cfg_rdata[9] == 1'b0) && (cfg_rdata[5:3] == 3'h0);
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed zero bits set");

  property p_aux;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=> (cfg_rdata[8:6] == (cfg_rdata[15] ? 3'h1 : 3'h0));
  endproperty
  a_aux: assert property (p_aux) else $error("aux current field wrong");

  property p_version;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=> (cfg_rdata[2:0] == 3'h2);
  endproperty
  a_version: assert property (p_version) else $error("version field wrong");

  property p_no_write;
    @(posedge clock) disable iff (reset)
    (cfg_write && !cfg_read && !misc_load) |=> $stable(cfg_rdata) && $stable(cap_word);
  endproperty
  a_no_write: assert property (p_no_write) else $error("write changed the word");

  property p_reset_value;
    @(posedge clock)
    disable iff (reset) (cfg_read && cap_hit && !loaded_since_reset) |=> (cfg_rdata == PMCW_CAP_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

  // answer timing: one ack per request cycle, read data held between reads
  property p_ack_follow;
    @(posedge clock) disable iff (reset)
    (cfg_read || cfg_write) |=>
      cfg_ack;
  endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack missing");

  property p_ack_idle;
    @(posedge clock) disable iff (reset)
    (!cfg_read && !cfg_write) |=>
      !cfg_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("stray ack");

  property p_rdata_hold;
    @(posedge clock) disable iff (reset)
    !cfg_read |=>
      $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");

  property p_other_zero;
    @(posedge clock) disable iff (reset)
    (cfg_read && !cap_hit) |=>
      (cfg_rdata == 16'h0000);
  endproperty
  a_other_zero: assert property (p_other_zero) else $error("other offset");

  // mirrors take the misc bits on a load and hold them otherwise
  property p_cold_load;
    @(posedge clock) disable iff (reset)
    misc_load |=>
      (wake_from_cold_off_capable == $past(misc_value[PMCW_COLD_BIT]));
  endproperty
  a_cold_load: assert property (p_cold_load) else $error("cold load");

  property p_cold_hold;
    @(posedge clock) disable iff (reset)
    !misc_load |=>
      $stable(wake_from_cold_off_capable);
  endproperty
  a_cold_hold: assert property (p_cold_hold) else $error("cold moved");

  property p_sel_load;
    @(posedge clock) disable iff (reset)
    misc_load |=>
      (wake_from_state_two_select == $past(misc_value[PMCW_SRC_D2_BIT]));
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("select load");

  property p_sel_hold;
    @(posedge clock) disable iff (reset)
    !misc_load |=>
      $stable(wake_from_state_two_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");

  property p_sup_load;
    @(posedge clock) disable iff (reset)
    misc_load |=>
      (state_two_supported == $past(misc_value[PMCW_D2_SUP_BIT]));
  endproperty
  a_sup_load: assert property (p_sup_load) else $error("support load");

  property p_sup_hold;
    @(posedge clock) disable iff (reset)
    !misc_load |=>
      $stable(state_two_supported);
  endproperty
  a_sup_hold: assert property (p_sup_hold) else $error("support moved");

  property p_word_hold;
    @(posedge clock) disable iff (reset)
    !misc_load |=>
      $stable(cap_word);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved");

  // read data against the mirrors sampled at the request edge
  property p_sel_read;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      (cfg_rdata[13] == $past(wake_from_state_two_select));
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("bit 13 read");

  property p_sup_read;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      (cfg_rdata[10] == $past(state_two_supported));
  endproperty
  a_sup_read: assert property (p_sup_read) else $error("bit 10 read");

  property p_aux_cold;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      (cfg_rdata[8:6] == ($past(wake_from_cold_off_capable) ? PMCW_AUX_55MA : PMCW_AUX_SELF));
  endproperty
  a_aux_cold: assert property (p_aux_cold) else $error("aux vs cold");

  // constant fields, one property each so a failure names its field
  property p_d1_zero;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      !cfg_rdata[9];
  endproperty
  a_d1_zero: assert property (p_d1_zero) else $error("bit 9 set");

  property p_dsi_zero;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      !cfg_rdata[5];
  endproperty
  a_dsi_zero: assert property (p_dsi_zero) else $error("bit 5 set");

  property p_rsvd_zero;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      !cfg_rdata[4];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("bit 4 set");

  property p_clk_zero;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      !cfg_rdata[3];
  endproperty
  a_clk_zero: assert property (p_clk_zero) else $error("bit 3 set");

  property p_src_low;
    @(posedge clock) disable iff (reset)
    (cfg_read && cap_hit) |=>
      (cfg_rdata[12:11] == {PMCW_SRC_STATE_ONE, PMCW_SRC_STATE_ZERO});
  endproperty
  a_src_low: assert property (p_src_low) else $error("bits 12:11");

  // reset clears the answer and restores the default word
  property p_reset_clear;
    @(posedge clock)
    reset |=>
      !cfg_ack && (cfg_rdata == 16'h0000) && !wake_from_cold_off_capable && (cap_word == PMCW_CAP_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("bad reset state");
endmodule

// >>> hw/pmcw_pkg.sv
// Purpose: constants for the power capability word of the configuration space
// Assumes: 16-bit configuration reads addressed by byte offset
// Notes:   only the capability word lives here; its mirrored source is outside
//
// What this block does
// - bit 15 shows the current cold-off wake capability bit of the misc config register.
// - bits 14 to 11 hold the wake source states, 1100b after reset.
// - bit 13 follows the state-two wake select bit of the misc config register.
// - bit 10 mirrors the state-two support bit, 1 meaning supported.
// - bit 9 always reads 0 because state one is not supported.
// - bits 8 to 6 read 000b when bit 15 is clear and 001b when it is set.
// - bit 5 reads 0 since no special initialization is needed.
// - reserved bit 4 always reads 0.
// - bit 3 reads 0 since no bus clock is needed to raise a wake request.
// - bits 2 to 0 always read 010b for register set revision 1.1.
// - the mirrored bits are loaded from the misc config register filled from serial rom.
package pmcw_pkg;

  localparam logic [7:0]  PMCW_CAP_OFFSET   = 8'h46;
  localparam logic [7:0]  PMCW_MISC_OFFSET  = 8'hF0;
  localparam logic [15:0] PMCW_CAP_RESET    = 16'h6402;

  // field positions inside the capability word and the misc config register
  localparam int PMCW_COLD_BIT     = 15;
  localparam int PMCW_SRC_HI       = 14;
  localparam int PMCW_SRC_LO       = 11;
  localparam int PMCW_SRC_D2_BIT   = 13;
  localparam int PMCW_D2_SUP_BIT   = 10;
  localparam int PMCW_D1_SUP_BIT   = 9;
  localparam int PMCW_AUX_HI       = 8;
  localparam int PMCW_AUX_LO       = 6;
  localparam int PMCW_DSI_BIT      = 5;
  localparam int PMCW_RSVD_BIT     = 4;
  localparam int PMCW_CLK_BIT      = 3;
  localparam int PMCW_VER_HI       = 2;

  // fixed field values
  localparam logic [1:0] PMCW_SRC_HOT_D3    = 2'h3;  // bits 14,13 default set
  localparam logic       PMCW_SRC_STATE_ONE = 1'b0;  // bit 12
  localparam logic       PMCW_SRC_STATE_ZERO = 1'b0; // bit 11
  localparam logic [2:0] PMCW_AUX_SELF      = 3'h0;
  localparam logic [2:0] PMCW_AUX_55MA      = 3'h1;
  localparam logic [2:0] PMCW_VERSION       = 3'h2;

  // reset values of the mirrored source bits
  localparam logic PMCW_COLD_RESET   = 1'b0;
  localparam logic PMCW_SRC_D2_RESET = 1'b1;
  localparam logic PMCW_D2_SUP_RESET = 1'b1;

endpackage

// >>> dv/pmcw_host.sv
// Purpose: host side model issuing configuration accesses and misc loads
// Assumes: one request at a time, answer sampled on a rising edge
// Notes:   released address and data show the inverse, not the last value
`timescale 1ns/1ps
module pmcw_host
(
  input  wire logic        clock,
  output logic             cfg_read,
  output logic             cfg_write,
  output logic [7:0]       cfg_addr,
  output logic [15:0]      cfg_wdata,
  output logic             misc_load,
  output logic [15:0]      misc_value,
  input  wire logic        cfg_ack,
  input  wire logic [15:0] cfg_rdata
);
  // idle state; the misc source keeps state-two support set by default
  initial
  begin
    cfg_read = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 16'h0000;
    misc_load = 1'b0;
    misc_value = 16'h0400;
  end
  // one-cycle request pulse, then a bounded wait for the answer
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    @(posedge clock);
    cfg_read <= !wr;
    cfg_write <= wr;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_read <= 1'b0;
    cfg_write <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    ok = 1'b0;
    for (int n = 0; n < 3 && !ok; n++)
    begin
      @(posedge clock);
      ok = (cfg_ack === 1'b1);
      q = cfg_rdata;
    end
  endtask
  // a misc load followed at once by a read, so a read lands in the very
  // cycle after the mirrors change
  task automatic load_read(input logic [15:0] v, output logic [15:0] q, output logic ok);
    @(posedge clock);
    misc_load <= 1'b1;
    misc_value <= v;
    @(posedge clock);
    misc_load <= 1'b0;
    misc_value <= ~v;
    cfg_read <= 1'b1;
    cfg_addr <= 8'h46;
    @(posedge clock);
    cfg_read <= 1'b0;
    cfg_addr <= 8'hB9;
    ok = 1'b0;
    for (int n = 0; n < 3 && !ok; n++)
    begin
      @(posedge clock);
      ok = (cfg_ack === 1'b1);
      q = cfg_rdata;
    end
  endtask
  // the misc register presents a new value for one cycle
  task automatic load(input logic [15:0] v);
    @(posedge clock);
    misc_load <= 1'b1;
    misc_value <= v;
    @(posedge clock);
    misc_load <= 1'b0;
    misc_value <= ~v;
  endtask
endmodule

// >>> dv/test_pci_power_capability_word.sv
// Purpose: self-checking bench for the power capability word
// Assumes: host model drives all request pins; reset is driven here
// Notes:   misc values past the corner ones come from an lfsr, so every run repeats exactly
`timescale 1ns/1ps
module test_pci_power_capability_word;
  import pmcw_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        cfg_read, cfg_write, misc_load, cfg_ack, cold, ok;
  logic [7:0]  cfg_addr;
  logic [15:0] cfg_wdata, misc_value, cfg_rdata, v, q;
  logic [15:0] seed = 16'h175D;
  int          bad_count = 0;
  int          compares = 0;
  always #12.5 clock = ~clock;
  pmcw_top u_pmcw_top (.clock(clock), .reset(reset), .cfg_read(cfg_read),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .misc_load(misc_load), .misc_value(misc_value), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .wake_from_cold_off_capable(cold));
  pmcw_host u_pmcw_host (.clock(clock), .cfg_read(cfg_read), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .misc_load(misc_load),
    .misc_value(misc_value), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // expected word built field by field from the misc source bits
  function automatic logic [15:0] expect_word(input logic [15:0] m);
    return {m[15], 1'b1, m[13], 2'b00, m[10], 3'b000, m[15], 3'b000, 3'b010};
  endfunction
  function automatic logic [15:0] next_seed(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic give_verdict();
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      bad_count++;
    end
  endtask
  // a missing answer counts as a mismatch and ends the run
  task automatic take(input logic [15:0] e);
    chk("cfg_rdata", e, ok ? q : ~e);
    if (!ok)
      give_verdict();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_pmcw_host.access(1'b0, a, 16'h0000, q, ok);
    take(e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // corner values first, then random misc contents, each followed by a write
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(8'h46, PMCW_CAP_RESET);
    for (int i = 0; i < 24; i++)
    begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (seed | 16'h0400);
      seed = next_seed(seed);
      if (i[0])
      begin
        u_pmcw_host.load_read(v, q, ok);
        take(expect_word(v));
      end
      else
        u_pmcw_host.load(v);
      rd(8'h46, expect_word(v));
      chk("cold_mirror", {15'h0000, v[15]}, {15'h0000, cold});
      u_pmcw_host.access(1'b1, 8'h46, ~expect_word(v), q, ok);
      chk("write_ack", 16'h0001, {15'h0000, ok});
      take(expect_word(v));
      rd(8'h46, expect_word(v));
    end
    // a reset in mid-run, taken while every mirror is set, brings the defaults back
    u_pmcw_host.load(16'hFFFF);
    rd(8'h46, expect_word(16'hFFFF));
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    chk("reset_rdata", 16'h0000, cfg_rdata);
    chk("reset_cold", 16'h0000, {15'h0000, cold});
    reset <= 1'b0;
    rd(8'h46, PMCW_CAP_RESET);
    rd(8'hF0, 16'h0000);
    give_verdict();
  end
endmodule
